// ---- verilog/rom_table_consts.svh ----
/*
  Offsets, field positions, reset values and slot counts of the debug
  component lookup table. Included by the table's module.
*/
`ifndef ROM_TABLE_CONSTS_SVH
`define ROM_TABLE_CONSTS_SVH

`define TBL_ENTRY_FIRST     12'h000
`define TBL_RESV_START      12'hf00
`define TBL_RESV_END        12'hfcb
`define TBL_MEMKIND_OFF     12'hfcc
`define TBL_PID4_OFF        12'hfd0
`define TBL_PID0_OFF        12'hfe0
`define TBL_PID1_OFF        12'hfe4
`define TBL_CID0_OFF        12'hff0
`define TBL_CID1_OFF        12'hff4
`define TBL_CID2_OFF        12'hff8
`define TBL_CID3_OFF        12'hffc
`define TBL_WORD_SLOTS      10'd960
`define TBL_BYTE_SLOTS      10'd240
`define TBL_NUM_ENTRIES     4
`define TBL_OFFS_LSB        12
`define TBL_FORMAT_BIT      1
`define TBL_PRESENT_BIT     0
`define TBL_CLASS_TABLE     4'h1
`define TBL_BLOCK_COUNT     4'h0
`define TBL_CID0_VAL        8'h0d
`define TBL_CID2_VAL        8'h05
`define TBL_CID3_VAL        8'hb1
`define TBL_CID1_LOW        4'h0
`define TBL_RDATA_RESET     32'h0000_0000

`endif

// ---- verilog/rom_table_pkg.sv ----
/*
  Types shared by the debug component lookup table.
  Assumes the constants header is on the include path.
*/
package rom_table_pkg;
  typedef enum logic {
    fmt_byte_wide,
    fmt_word_wide
  } table_format_t;

  typedef struct packed {
    logic [31:0] rdata_reg;
    logic        rvalid_reg;
  } table_state_t;
endpackage

// ---- verilog/rom_table.sv ----
/*
  Read-only 4KB lookup table of debug components, a word-read slave of the
  debug memory bus. Assumes a simple request/read-data bus on the debugger
  side, the bus clock and reset, and static tie-offs held steady.
*/
// Behaviour
// [RULE1] Entries are four bytes: one word, or four byte slots LSB first.
// [RULE2] Entry bits 31:12 hold signed offset of component from table base.
// [RULE3] Offset field of every entry, even absent ones, is nonzero.
// [RULE4] Entry bits 11:2 read as zero.
// [RULE5] Entry bit 1 gives table width, same in every entry.
// [RULE6] Entry bit 0 is one for a present component, else zero.
// [RULE7] Debugger computes component base as table base plus offset shifted 12.
// [RULE8] Debugger reads block count from identification word four at base plus fd0.
// [RULE9] Debugger skips absent entries, not taking them as list end.
// [RULE10] A blank all-zero entry follows the last component entry.
// [RULE11] Byte-wide blank entry is four zero bytes at a 16-byte boundary.
// [RULE12] Debugger never takes one zero byte as the list end.
// [RULE13] Table fills exactly one 4KB block, first entry at offset zero.
// [RULE14] Space after the blank entry through fcb reads as zero.
// [RULE15] At most 240 byte-wide or 960 word-wide entries; full table unterminated.
// [RULE16] Read-only memory-kind register sits at offset fcc.
// [RULE17] Memory-kind bit 0 flags shared system memory; upper bits zero.
// [RULE18] With shared flag clear, debugger reads only addresses the table lists.
// [RULE19] Identification values follow the presence tie-offs.
// [RULE20] Writes are ignored; contents never change.
// [RULE21] Byte-wide reads return the byte in 7:0, zero above.
// [RULE22] Component class field of identification word one reads one.
// [RULE23] Block count field of identification word four reads zero.
// [RULE24] Reads decode address bits 11:2 and return a full word.
// [RULE25] Debugger finds start as base minus count times 4KB.
`timescale 1ns/1ns
`include "rom_table_consts.svh"

module rom_table
  import rom_table_pkg::*;
#(
  parameter bit          WORD_WIDE    = 1'b1,
  parameter bit          SHARED_MEM   = 1'b0,
  parameter logic [19:0] OFFS0        = 20'h00001,
  parameter logic [19:0] OFFS1        = 20'h00002,
  parameter logic [19:0] OFFS2        = 20'hfff00,
  parameter logic [19:0] OFFS3        = 20'h00010,
  // Identity values: arbitrary, chosen neutral
  parameter logic [11:0] PART_NUM     = 12'h5a5,
  parameter logic [3:0]  DESIGNER_LO  = 4'h3,
  parameter logic [2:0]  DESIGNER_HI  = 3'h2,
  parameter logic [3:0]  CONT_CODE    = 4'h0,
  parameter logic [3:0]  REVISION     = 4'h0,
  parameter logic [3:0]  CUST_MOD     = 4'h0
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // Static presence tie-offs, one per entry
  input  wire logic [`TBL_NUM_ENTRIES-1:0]       present_tie,
  // Debug memory bus
  input  wire logic                              sel,
  input  wire logic                              write,
  input  wire logic [11:0]                       addr,
  input  wire logic [31:0]                       wdata,
  output      logic [31:0]                       rdata,
  output      logic                              rvalid
);

  table_state_t state_reg;
  table_state_t state_next;
  logic [`TBL_NUM_ENTRIES-1:0] tie_s1_reg;
  logic [`TBL_NUM_ENTRIES-1:0] tie_s2_reg;

  localparam table_format_t FMT = WORD_WIDE ? fmt_word_wide : fmt_byte_wide;

  // Tie-offs are straps from outside the clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tie_s1_reg <= '0;
      tie_s2_reg <= '0;
    end else begin
      tie_s1_reg <= present_tie;
      tie_s2_reg <= tie_s1_reg;
    end
  end

  // Offsets must never be zero, or the entry would point back here
  function automatic logic [19:0] entry_offs(input logic [1:0] idx);
    unique case (idx)
      2'd0: entry_offs = OFFS0;
      2'd1: entry_offs = OFFS1;
      2'd2: entry_offs = OFFS2;
      2'd3: entry_offs = OFFS3;
    endcase
  endfunction

  function automatic logic [31:0] entry_word(input logic [1:0] idx);
    entry_word = {entry_offs(idx), 10'h000,                    // RULE2 RULE4
                  (FMT == fmt_word_wide), tie_s2_reg[idx]};    // RULE5 RULE6
  endfunction

  // Read value of the slot at word index w, from its entry index and byte lane
  function automatic logic [31:0] table_slot(input logic [9:0] w);
    logic [7:0]  byte_idx;
    logic [31:0] ent;
    byte_idx = w[9:2];
    table_slot = 32'h0000_0000;
    if (FMT == fmt_word_wide) begin
      if (w < 10'(`TBL_NUM_ENTRIES))                           // RULE10 RULE14
        table_slot = entry_word(w[1:0]);                       // RULE1
    end else if (byte_idx < 8'(`TBL_NUM_ENTRIES)) begin
      ent = entry_word(byte_idx[1:0]);
      table_slot = {24'h000000, ent[8*w[1:0] +: 8]};           // RULE1 RULE11 RULE21
    end
  endfunction

  // Topology digest folds the tie-offs into the revision field
  logic [3:0] topo_rev;
  assign topo_rev = REVISION ^ 4'(tie_s2_reg);                 // RULE19

  logic [31:0] read_word;
  always_comb begin
    read_word = 32'h0000_0000;
    unique case ({addr[11:2], 2'b00})                          // RULE24 RULE13
      `TBL_MEMKIND_OFF: read_word = {31'h0, SHARED_MEM};       // RULE16 RULE17
      `TBL_PID4_OFF:    read_word = {24'h0, `TBL_BLOCK_COUNT, CONT_CODE}; // RULE23
      12'hfe0:          read_word = {24'h0, PART_NUM[7:0]};
      12'hfe4:          read_word = {24'h0, DESIGNER_LO, PART_NUM[11:8]};
      12'hfe8:          read_word = {24'h0, topo_rev, 1'b1, DESIGNER_HI};
      12'hfec:          read_word = {24'h0, 4'h0, CUST_MOD};
      `TBL_CID0_OFF:    read_word = {24'h0, `TBL_CID0_VAL};
      `TBL_CID1_OFF:    read_word = {24'h0, `TBL_CLASS_TABLE, `TBL_CID1_LOW}; // RULE22
      `TBL_CID2_OFF:    read_word = {24'h0, `TBL_CID2_VAL};
      `TBL_CID3_OFF:    read_word = {24'h0, `TBL_CID3_VAL};
      default: begin
        if (addr < `TBL_RESV_START)
          read_word = table_slot(addr[11:2]);                  // RULE14 RULE15
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.rvalid_reg = sel;
    // Writes are answered but change nothing
    if (sel && !write)                                         // RULE20
      state_next.rdata_reg = read_word;
    else if (sel)
      state_next.rdata_reg = 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.rdata_reg  <= `TBL_RDATA_RESET;
      state_reg.rvalid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata  = state_reg.rdata_reg;
  assign rvalid = state_reg.rvalid_reg;

  a_memkind_read: assert property (@(posedge clk) disable iff (!rst_n)
    sel && !write && addr[11:2] == 10'h3f3 |=> rvalid && rdata == {31'h0, SHARED_MEM})
    else $error("memory-kind read wrong"); // RULE17

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    sel && !write && addr >= `TBL_RESV_START && addr <= `TBL_RESV_END |=> rdata == 32'h0)
    else $error("reserved area not zero"); // RULE14

  a_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    sel && write |=> rvalid && rdata == 32'h0)
    else $error("write produced data"); // RULE20

  a_class_field: assert property (@(posedge clk) disable iff (!rst_n)
    sel && !write && addr[11:2] == 10'h3fd |=> rdata[7:4] == 4'h1)
    else $error("class field wrong"); // RULE22

  a_block_count: assert property (@(posedge clk) disable iff (!rst_n)
    sel && !write && addr[11:2] == 10'h3f4 |=> rdata[7:4] == 4'h0)
    else $error("block count nonzero"); // RULE23

  a_entry_format: assert property (@(posedge clk) disable iff (!rst_n)
    sel && !write && WORD_WIDE && addr[11:2] < 10'd4
    |=> rdata[11:2] == 10'h0 && rdata[1] && rdata[31:12] != 20'h0)
    else $error("entry fields wrong"); // RULE3

  a_blank_end: assert property (@(posedge clk) disable iff (!rst_n)
    sel && !write && WORD_WIDE && addr[11:2] == 10'd4 |=> rdata == 32'h0)
    else $error("missing blank entry"); // RULE10

  a_byte_lane: assert property (@(posedge clk) disable iff (!rst_n)
    sel && !write && !WORD_WIDE && addr < `TBL_RESV_START |=> rdata[31:8] == 24'h0)
    else $error("byte table upper bits set"); // RULE21

  a_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    !sel |=> !rvalid)
    else $error("answer without request"); // RULE24

endmodule

// ---- verif/debug_bus_master.sv ----
/*
  Debugger-side bus master model for the lookup table.
  Assumes the table answers one cycle after a one-cycle request.
*/
`timescale 1ns/1ns
module debug_bus_master (
  // Clock
  input  wire logic        clk,
  // Request side
  output      logic        sel,
  output      logic        write,
  output      logic [11:0] addr,
  output      logic [31:0] wdata,
  // Answers of the word-wide and byte-wide tables
  input  wire logic [31:0] rdata_w,
  input  wire logic [31:0] rdata_b,
  input  wire logic        rvalid
);
  initial begin
    sel = 1'b0;
    write = 1'b0;
    addr = 12'h0;
    wdata = 32'h0;
  end
  // Idle cycles first let the model be slow as well as prompt
  task automatic access(input logic wr, input logic [11:0] a, input int gap,
                        output logic [31:0] qw, output logic [31:0] qb);
    repeat (gap) @(posedge clk);
    sel <= 1'b1;
    write <= wr;
    addr <= a;
    wdata <= 32'hffff_ffff;
    @(posedge clk);
    // Released lines flip, so a stale address cannot pass for a driven one
    sel <= 1'b0;
    addr <= ~a;
    wdata <= 32'h0;
    // Answer is taken mid-cycle, clear of the edge that launches it
    @(negedge clk);
    qw = (rvalid === 1'b1) ? rdata_w : 32'hxxxx_xxxx;
    qb = rdata_b;
    @(posedge clk);
  endtask
endmodule

// ---- verif/debug_component_rom_table_test.sv ----
/*
  Self-checking bench: word-wide and byte-wide tables share one bus model.
  Assumes the table package and constants header are compiled first.
*/
`timescale 1ns/1ns
module debug_component_rom_table_test;
  import rom_table_pkg::*;
  logic        clk, rst_n, sel, write, rvalid;
  logic [3:0]  tie;
  logic [11:0] addr;
  logic [31:0] wdata, rdata_w, rdata_b, qw, qb;
  int          mismatches, check_count, cycles;
  logic [19:0] offs [4] = '{20'h00001, 20'h00002, 20'hfff00, 20'h00010};

  rom_table #(.WORD_WIDE(1'b1)) rom_table_inst (.clk(clk), .rst_n(rst_n), .present_tie(tie),
    .sel(sel), .write(write), .addr(addr), .wdata(wdata), .rdata(rdata_w), .rvalid(rvalid));
  rom_table #(.WORD_WIDE(1'b0)) rom_table_byte_inst (.clk(clk), .rst_n(rst_n),
    .present_tie(tie), .sel(sel), .write(write), .addr(addr), .wdata(wdata),
    .rdata(rdata_b), .rvalid());
  debug_bus_master debug_bus_master_inst (.clk(clk), .sel(sel), .write(write), .addr(addr),
    .wdata(wdata), .rdata_w(rdata_w), .rdata_b(rdata_b), .rvalid(rvalid));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] entry(input int k, input logic wide);
    return {offs[k], 10'h0, wide, tie[k]};
  endfunction
  task automatic rd(input logic [11:0] a, input int gap);
    debug_bus_master_inst.access(1'b0, a, gap, qw, qb);
  endtask
  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic test_entries();
    logic [31:0] eb;
    for (int i = 0; i < 20; i++) begin
      rd(12'(i * 4 + i % 4), i % 3);
      eb = (i < 16) ? entry(i / 4, 1'b0) >> (8 * (i % 4)) : 32'h0;
      check(qw, (i < 4) ? entry(i, 1'b1) : 32'h0);
      check(qb, {24'h0, eb[7:0]});
    end
    $display("test_entries done");
  endtask
  task automatic test_regions();
    logic [11:0] a [5] = '{12'h0fc, 12'hefc, 12'hf00, 12'hfc8, 12'hfcc};
    foreach (a[j]) begin
      rd(a[j], 0);
      check(qw, 32'h0);
      check(qb, 32'h0);
    end
    rd(12'hff4, 0);
    check({28'h0, qw[7:4]}, 32'h1);
    rd(12'hfd0, 1);
    check({28'h0, qb[7:4]}, 32'h0);
    $display("test_regions done");
  endtask
  task automatic test_writes();
    debug_bus_master_inst.access(1'b1, 12'h000, 0, qw, qb);
    check(qw, 32'h0);
    debug_bus_master_inst.access(1'b1, 12'hfcc, 0, qw, qb);
    rd(12'h000, 0);
    check(qw, entry(0, 1'b1));
    rd(12'hfcc, 0);
    check(qw, 32'h0);
    $display("test_writes done");
  endtask
  task automatic test_walk();
    int found;
    logic [31:0] base;
    found = 0;
    // Absent entries are skipped; only an all-zero word ends the list
    for (int k = 0; k < 960; k++) begin
      rd(12'(k * 4), 0);
      if (qw === 32'h0) break;
      if (qw[0] === 1'b1) found++;
    end
    check(32'(found), 32'($countones(tie)));
    // Locate entry 1 as a debugger would; the table's own count word stands in
    rd(12'h004, 0);
    base = {qw[31:12], 12'h000};
    check(base, {offs[1], 12'h000});
    rd(12'hfd0, 0);
    check(base - (32'(qw[7:4]) << 12), {offs[1], 12'h000});
    rd(12'hfe8, 0);
    check({28'h0, qw[7:4]}, {28'h0, tie});
    tie <= 4'b0100;
    repeat (3) @(posedge clk);
    rd(12'hfe8, 0);
    check({28'h0, qw[7:4]}, 32'h4);
    rd(12'h000, 0);
    check(qw, entry(0, 1'b1));
    $display("test_walk done");
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    rst_n = 1'b0;
    tie = 4'b1011;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Straps need two edges after release to settle
    repeat (3) @(posedge clk);
    test_entries();
    test_regions();
    test_writes();
    test_walk();
    complete_run();
  end
endmodule
